/* File: design/dcea_top.sv */
// DMA channel enable and primary/alternate select with AXI4-Lite access
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dcea_top (
  // Clock, reset, enable
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_ce,
  // Write address
  input  wire logic [31:0]                 i_s_axi_awaddr,
  input  wire logic                        i_s_axi_awvalid,
  output logic                             o_s_axi_awready,
  // Write data
  input  wire logic [31:0]                 i_s_axi_wdata,
  input  wire logic [3:0]                  i_s_axi_wstrb,
  input  wire logic                        i_s_axi_wvalid,
  output logic                             o_s_axi_wready,
  // Write response
  output logic [1:0]                       o_s_axi_bresp,
  output logic                             o_s_axi_bvalid,
  input  wire logic                        i_s_axi_bready,
  // Read address
  input  wire logic [31:0]                 i_s_axi_araddr,
  input  wire logic                        i_s_axi_arvalid,
  output logic                             o_s_axi_arready,
  // Read data
  output logic [31:0]                      o_s_axi_rdata,
  output logic [1:0]                       o_s_axi_rresp,
  output logic                             o_s_axi_rvalid,
  input  wire logic                        i_s_axi_rready,
  // Transfer engine events
  input  wire logic [dcea_pkg::CHAN_N-1:0] i_cycle_done,
  input  wire logic [dcea_pkg::CHAN_N-1:0] i_alt_hw_set,
  input  wire logic [dcea_pkg::CHAN_N-1:0] i_alt_hw_clr,
  // Channel state
  output logic [dcea_pkg::CHAN_N-1:0]      o_chan_enable,
  output logic [dcea_pkg::CHAN_N-1:0]      o_alt_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel state

  typedef struct packed {
    logic                 aw_full;
    logic                 w_full;
    dcea_pkg::dcea_wreq_s req;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
  } dcea_wr_state_s;

  dcea_wr_state_s s_q;
  dcea_wr_state_s s_d;

  logic                 wr_en;
  logic                 wr_mapped;
  dcea_pkg::dcea_chan_t wr_bits;
  dcea_pkg::dcea_chan_t sw_en_set;
  dcea_pkg::dcea_chan_t sw_en_clr;
  dcea_pkg::dcea_chan_t sw_alt_set;
  dcea_pkg::dcea_chan_t sw_alt_clr;
  dcea_pkg::dcea_upd_s  en_upd;
  dcea_pkg::dcea_upd_s  alt_upd;

  // Commit once both halves are held and no response pending
  assign wr_en = i_ce & s_q.aw_full & s_q.w_full & ~s_q.bvalid;

  assign wr_mapped = dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_EN_SET)
                   | dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_EN_CLR)
                   | dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_ALT_SET)
                   | dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_ALT_CLR);

  assign wr_bits = s_q.req.data[dcea_pkg::CHAN_N-1:0]
                 & dcea_pkg::lane_mask(s_q.req.strb);

  always_comb begin
    s_d = s_q;
    if (i_ce) begin
      if (s_q.awready && i_s_axi_awvalid) begin
        s_d.aw_full  = 1'b1;
        s_d.req.addr = i_s_axi_awaddr;
      end
      if (s_q.wready && i_s_axi_wvalid) begin
        s_d.w_full   = 1'b1;
        s_d.req.data = i_s_axi_wdata;
        s_d.req.strb = i_s_axi_wstrb;
      end
      if (wr_en) begin
        s_d.aw_full = 1'b0;
        s_d.w_full  = 1'b0;
        s_d.bvalid  = 1'b1;
        s_d.bresp   = wr_mapped ? dcea_pkg::RESP_OKAY : dcea_pkg::RESP_SLVERR;
      end else if (s_q.bvalid && i_s_axi_bready) begin
        s_d.bvalid = 1'b0;
      end
      s_d.awready = ~s_d.aw_full & ~s_d.bvalid;
      s_d.wready  = ~s_d.w_full & ~s_d.bvalid;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_s_axi_awready = s_q.awready;
  assign o_s_axi_wready  = s_q.wready;
  assign o_s_axi_bvalid  = s_q.bvalid;
  assign o_s_axi_bresp   = s_q.bresp;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode into set/clear vectors

  always_comb begin
    sw_en_set  = '0;
    sw_en_clr  = '0;
    sw_alt_set = '0;
    sw_alt_clr = '0;
    if (wr_en) begin
      if (dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_EN_SET)) begin
        sw_en_set = wr_bits;
      end
      if (dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_EN_CLR)) begin
        sw_en_clr = wr_bits;
      end
      if (dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_ALT_SET)) begin
        sw_alt_set = wr_bits;
      end
      if (dcea_pkg::hit(s_q.req.addr, dcea_pkg::OFS_ALT_CLR)) begin
        sw_alt_clr = wr_bits;
      end
    end
  end

  always_comb begin
    en_upd.sw_set  = sw_en_set;
    en_upd.sw_clr  = sw_en_clr;
    en_upd.hw_set  = '0;
    en_upd.hw_clr  = i_cycle_done;
    alt_upd.sw_set = sw_alt_set;
    alt_upd.sw_clr = sw_alt_clr;
    alt_upd.hw_set = i_alt_hw_set;
    alt_upd.hw_clr = i_alt_hw_clr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel flags and read side

  dcea_chflag u_enable (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_ce       (i_ce),
    .i_upd      (en_upd),
    .o_flag     (o_chan_enable)
  );

  dcea_chflag u_alt (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_ce       (i_ce),
    .i_upd      (alt_upd),
    .o_flag     (o_alt_select)
  );

  dcea_axil_rd u_rd (
    .i_core_clk      (i_core_clk),
    .i_reset_n       (i_reset_n),
    .i_ce            (i_ce),
    .i_s_axi_araddr  (i_s_axi_araddr),
    .i_s_axi_arvalid (i_s_axi_arvalid),
    .o_s_axi_arready (o_s_axi_arready),
    .o_s_axi_rdata   (o_s_axi_rdata),
    .o_s_axi_rresp   (o_s_axi_rresp),
    .o_s_axi_rvalid  (o_s_axi_rvalid),
    .i_s_axi_rready  (i_s_axi_rready),
    .i_enable        (o_chan_enable),
    .i_alt           (o_alt_select)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  dcea_pkg::dcea_chan_t en_set_eff;
  dcea_pkg::dcea_chan_t alt_set_eff;
  dcea_pkg::dcea_chan_t alt_clr_eff;
  dcea_pkg::dcea_chan_t alt_hw_eff;
  logic                 ar_take;

  assign en_set_eff  = sw_en_set & ~i_cycle_done;
  assign alt_set_eff = sw_alt_set & ~i_alt_hw_clr;
  assign alt_clr_eff = sw_alt_clr & ~i_alt_hw_set;
  assign alt_hw_eff  = i_alt_hw_set & ~i_alt_hw_clr;
  assign ar_take     = i_ce & o_s_axi_arready & i_s_axi_arvalid;

  property p_en_set;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (en_set_eff != '0)
    |=> (o_chan_enable & $past(en_set_eff)) == $past(en_set_eff);
  endproperty
  a_en_set: assert property (p_en_set)
    else $error("enable-set write did not enable the channel");

  property p_en_no_rise;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (sw_en_set == '0)
    |=> (o_chan_enable & ~$past(o_chan_enable)) == '0;
  endproperty
  a_en_no_rise: assert property (p_en_no_rise)
    else $error("channel enabled without a set write");

  property p_en_clr;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (sw_en_clr != '0)
    |=> (o_chan_enable & $past(sw_en_clr)) == '0;
  endproperty
  a_en_clr: assert property (p_en_clr)
    else $error("enable-clear write did not disable the channel");

  property p_en_no_fall;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (sw_en_clr == '0) && (i_cycle_done == '0)
    |=> (~o_chan_enable & $past(o_chan_enable)) == '0;
  endproperty
  a_en_no_fall: assert property (p_en_no_fall)
    else $error("channel disabled without a clear or completion");

  property p_done_clr;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (i_cycle_done != '0)
    |=> (o_chan_enable & $past(i_cycle_done)) == '0;
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("completed channel still enabled");

  property p_done_wins;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && ((sw_en_set & i_cycle_done) != '0)
    |=> (o_chan_enable & $past(i_cycle_done)) == '0;
  endproperty
  a_done_wins: assert property (p_done_wins)
    else $error("software set beat cycle completion");

  property p_alt_set;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (alt_set_eff != '0)
    |=> (o_alt_select & $past(alt_set_eff)) == $past(alt_set_eff);
  endproperty
  a_alt_set: assert property (p_alt_set)
    else $error("alternate-set write did not select alternate");

  property p_alt_hold;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (sw_alt_set == '0) && (i_alt_hw_set == '0)
    |=> (o_alt_select & ~$past(o_alt_select)) == '0;
  endproperty
  a_alt_hold: assert property (p_alt_hold)
    else $error("alternate selected without a set");

  property p_alt_clr;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (alt_clr_eff != '0)
    |=> (o_alt_select & $past(alt_clr_eff)) == '0;
  endproperty
  a_alt_clr: assert property (p_alt_clr)
    else $error("alternate-clear write did not select primary");

  property p_alt_hw;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && (alt_hw_eff != '0)
    |=> (o_alt_select & $past(alt_hw_eff)) == $past(alt_hw_eff);
  endproperty
  a_alt_hw: assert property (p_alt_hw)
    else $error("hardware alternate set was lost");

  property p_rd_en;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    ar_take && (dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_EN_SET) ||
                dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_EN_CLR))
    |=> o_s_axi_rvalid && (o_s_axi_rresp == dcea_pkg::RESP_OKAY)
        && (o_s_axi_rdata == {dcea_pkg::RSVD_RD, $past(o_chan_enable)});
  endproperty
  a_rd_en: assert property (p_rd_en)
    else $error("enable read returned wrong status");

  property p_rd_alt;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    ar_take && dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_ALT_SET)
    |=> o_s_axi_rvalid
        && (o_s_axi_rdata == {dcea_pkg::RSVD_RD, $past(o_alt_select)});
  endproperty
  a_rd_alt: assert property (p_rd_alt)
    else $error("alternate read returned wrong status");

  property p_reset;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(i_reset_n)
    |-> (o_chan_enable == '0) && (o_alt_select == '0) && !o_s_axi_bvalid;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");

  property p_wr_resp;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    wr_en |=> o_s_axi_bvalid ##0 o_s_axi_bvalid [*1];
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing after commit");

  property p_wr_err;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    wr_en && !wr_mapped |=> o_s_axi_bvalid && (o_s_axi_bresp == dcea_pkg::RESP_SLVERR);
  endproperty
  a_wr_err: assert property (p_wr_err)
    else $error("unmapped write not answered with an error");

  property p_ce_freeze;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_ce |=> $stable(o_chan_enable) && $stable(o_alt_select);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("channel state moved while clock enable was low");

  property p_alt_clr_wins;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_ce && ((sw_alt_set & i_alt_hw_clr) != '0)
    |=> (o_alt_select & $past(i_alt_hw_clr)) == '0;
  endproperty
  a_alt_clr_wins: assert property (p_alt_clr_wins)
    else $error("software alternate set beat engine primary select");

  property p_rd_alt_clr;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    ar_take && dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_ALT_CLR)
    |=> o_s_axi_rvalid && (o_s_axi_rresp == dcea_pkg::RESP_OKAY)
        && (o_s_axi_rdata == {dcea_pkg::RSVD_RD, $past(o_alt_select)});
  endproperty
  a_rd_alt_clr: assert property (p_rd_alt_clr)
    else $error("alternate-clear read returned wrong status");

  c_en_write: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    sw_en_set != '0 ##1 o_s_axi_bvalid);
  c_done: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (o_chan_enable & i_cycle_done) != '0);
  c_alt_pingpong: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_alt_hw_set != '0 ##[1:20] i_alt_hw_clr != '0);
  c_rd_alt: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ar_take && dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_ALT_SET));

endmodule

/* File: design/dcea_pkg.sv */
// Package: constants, types and helpers of the DMA channel enable/alternate block
package dcea_pkg;

  localparam int unsigned CHAN_N = 14;

  localparam logic [31:0] OFS_EN_SET  = 32'h4001_0028;
  localparam logic [31:0] OFS_EN_CLR  = 32'h4001_002c;
  localparam logic [31:0] OFS_ALT_SET = 32'h4001_0030;
  localparam logic [31:0] OFS_ALT_CLR = 32'h4001_0034;

  localparam logic [CHAN_N-1:0] RST_CHAN = 14'h0000;
  localparam logic [17:0]       RSVD_RD  = 18'h00000;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  typedef logic [CHAN_N-1:0] dcea_chan_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } dcea_wreq_s;

  typedef struct packed {
    dcea_chan_t sw_set;
    dcea_chan_t sw_clr;
    dcea_chan_t hw_set;
    dcea_chan_t hw_clr;
  } dcea_upd_s;

  // Channel bits covered by the written byte lanes
  function automatic dcea_chan_t lane_mask(input logic [3:0] strb);
    lane_mask = {{6{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Word address match
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
    hit = (addr[31:2] == ofs[31:2]);
  endfunction

endpackage

/* File: design/dcea_chflag.sv */
// Per-channel flag register with software and hardware set/clear
`timescale 1ns/1ps
module dcea_chflag (
  // Clock, reset, enable
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_ce,
  // Update vectors
  input  wire dcea_pkg::dcea_upd_s  i_upd,
  // Flag state
  output logic [dcea_pkg::CHAN_N-1:0] o_flag
);

  typedef struct packed {
    dcea_pkg::dcea_chan_t flag;
  } dcea_flag_state_s;

  dcea_flag_state_s s_q;
  dcea_flag_state_s s_d;

  always_comb begin
    s_d = s_q;
    if (i_ce) begin
      // Software first: ones act, zeros leave bits alone
      s_d.flag = (s_q.flag | i_upd.sw_set) & ~i_upd.sw_clr;
      // Hardware applied last so it wins
      s_d.flag = (s_d.flag | i_upd.hw_set) & ~i_upd.hw_clr;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s_q.flag <= dcea_pkg::RST_CHAN;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_flag = s_q.flag;

endmodule

/* File: design/dcea_axil_rd.sv */
// AXI4-Lite read channel returning channel enable and structure status
`timescale 1ns/1ps
module dcea_axil_rd (
  // Clock, reset, enable
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_ce,
  // Read address
  input  wire logic [31:0]                 i_s_axi_araddr,
  input  wire logic                        i_s_axi_arvalid,
  output logic                             o_s_axi_arready,
  // Read data
  output logic [31:0]                      o_s_axi_rdata,
  output logic [1:0]                       o_s_axi_rresp,
  output logic                             o_s_axi_rvalid,
  input  wire logic                        i_s_axi_rready,
  // Status
  input  wire logic [dcea_pkg::CHAN_N-1:0] i_enable,
  input  wire logic [dcea_pkg::CHAN_N-1:0] i_alt
);

  typedef struct packed {
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dcea_rd_state_s;

  dcea_rd_state_s s_q;
  dcea_rd_state_s s_d;

  always_comb begin
    s_d = s_q;
    if (i_ce) begin
      if (s_q.arready && i_s_axi_arvalid) begin
        s_d.rvalid = 1'b1;
        s_d.rresp  = dcea_pkg::RESP_OKAY;
        s_d.rdata  = 32'h0000_0000;
        if (dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_EN_SET) ||
            dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_EN_CLR)) begin
          s_d.rdata = {dcea_pkg::RSVD_RD, i_enable};
        end else if (dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_ALT_SET) ||
                     dcea_pkg::hit(i_s_axi_araddr, dcea_pkg::OFS_ALT_CLR)) begin
          s_d.rdata = {dcea_pkg::RSVD_RD, i_alt};
        end else begin
          s_d.rresp = dcea_pkg::RESP_SLVERR;
        end
      end else if (s_q.rvalid && i_s_axi_rready) begin
        s_d.rvalid = 1'b0;
      end
      s_d.arready = ~s_d.rvalid;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_s_axi_arready = s_q.arready;
  assign o_s_axi_rvalid  = s_q.rvalid;
  assign o_s_axi_rdata   = s_q.rdata;
  assign o_s_axi_rresp   = s_q.rresp;

endmodule

/* File: testbench/dma_channel_enable_alt_select_bench.sv */
// Self-checking bench for the DMA channel enable and structure select block
`timescale 1ns/1ps
module dma_channel_enable_alt_select_bench;
  logic                 clk      = 1'b0;
  logic                 rst_n    = 1'b0;
  logic                 ce       = 1'b1;
  logic [31:0]          awaddr   = '0;
  logic [31:0]          wdata    = '0;
  logic [31:0]          araddr   = '0;
  logic [3:0]           wstrb    = '0;
  logic                 awvalid  = 1'b0;
  logic                 wvalid   = 1'b0;
  logic                 bready   = 1'b0;
  logic                 arvalid  = 1'b0;
  logic                 rready   = 1'b0;
  dcea_pkg::dcea_chan_t cyc_done = '0;
  dcea_pkg::dcea_chan_t hw_set   = '0;
  dcea_pkg::dcea_chan_t hw_clr   = '0;
  dcea_pkg::dcea_chan_t exp_en   = '0;
  dcea_pkg::dcea_chan_t exp_alt  = '0;
  dcea_pkg::dcea_chan_t chan_en;
  dcea_pkg::dcea_chan_t alt_sel;
  logic                 awready;
  logic                 wready;
  logic                 bvalid;
  logic                 arready;
  logic                 rvalid;
  logic [1:0]           bresp;
  logic [1:0]           rresp;
  logic [31:0]          rdata;
  logic [29:0]          wexp;
  logic [33:0]          rd_q[$];
  logic [29:0]          wr_q[$];
  logic [31:0]          regs[5];
  int                   failures   = 0;
  int                   num_checks = 0;
  int                   seed       = 13555;

  always #12.5 clk = ~clk;

  dcea_top dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_ce(ce),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_cycle_done(cyc_done),
    .i_alt_hw_set(hw_set), .i_alt_hw_clr(hw_clr), .o_chan_enable(chan_en),
    .o_alt_select(alt_sel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Status word a read of this address should return
  function automatic logic [33:0] rd_exp(input logic [31:0] a);
    case (a)
      dcea_pkg::OFS_EN_SET, dcea_pkg::OFS_EN_CLR: rd_exp = {2'h0, 18'h0, exp_en};
      dcea_pkg::OFS_ALT_SET, dcea_pkg::OFS_ALT_CLR: rd_exp = {2'h0, 18'h0, exp_alt};
      default: rd_exp = {dcea_pkg::RESP_SLVERR, 32'h0};
    endcase
  endfunction

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        input dcea_pkg::dcea_chan_t hd, hs, hc);
    logic                 ad;
    logic                 wd;
    logic [1:0]           er;
    dcea_pkg::dcea_chan_t m;
    ad = 1'b0;
    wd = 1'b0;
    er = dcea_pkg::RESP_OKAY;
    m = {{6{s[1]}}, {8{s[0]}}} & d[13:0];
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    // Engine events land on the commit edge, racing the write
    cyc_done <= hd;
    hw_set <= hs;
    hw_clr <= hc;
    case (a)
      dcea_pkg::OFS_EN_SET: exp_en = exp_en | m;
      dcea_pkg::OFS_EN_CLR: exp_en = exp_en & ~m;
      dcea_pkg::OFS_ALT_SET: exp_alt = exp_alt | m;
      dcea_pkg::OFS_ALT_CLR: exp_alt = exp_alt & ~m;
      default: er = dcea_pkg::RESP_SLVERR;
    endcase
    exp_en = exp_en & ~hd;
    exp_alt = (exp_alt | hs) & ~hc;
    wr_q.push_back({er, exp_en, exp_alt});
    @(posedge clk);
    cyc_done <= '0;
    hw_set <= '0;
    hw_clr <= '0;
    do begin
      @(posedge clk);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a);
    @(posedge clk);
    rd_q.push_back(rd_exp(a));
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (rd_q.size() == 0) check("read_extra", 34'h1, 34'h0);
      else check("read", {rresp, rdata}, rd_q.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      if (wr_q.size() == 0) begin
        check("write_extra", 34'h1, 34'h0);
      end else begin
        wexp = wr_q.pop_front();
        check("bresp", bresp, wexp[29:28]);
        check("enable", chan_en, wexp[27:14]);
        check("alt", alt_sel, wexp[13:0]);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int          k;
    logic [31:0] r1, r2, r3, r4;
    regs = '{dcea_pkg::OFS_EN_SET, dcea_pkg::OFS_EN_CLR, dcea_pkg::OFS_ALT_SET,
             dcea_pkg::OFS_ALT_CLR, 32'h4001_0038};
    repeat (6) @(posedge clk);
    check("reset_en", chan_en, 34'h0);
    check("reset_alt", alt_sel, 34'h0);
    rst_n <= 1'b1;
    foreach (regs[i]) axi_rd(regs[i]);
    repeat (40) begin
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      r4 = $random(seed);
      k = (r1[31:28] % 5);
      axi_wr(regs[k], r4, r3[31:28], r1[13:0] & r2[13:0] & r3[13:0],
             r1[27:14] & r2[27:14], r2[27:14] & r3[27:14]);
      axi_rd(regs[r2[31:28] % 5]);
    end
    axi_wr(dcea_pkg::OFS_EN_SET, 32'hffff_ffff, 4'hf, '0, '0, '0);
    axi_wr(dcea_pkg::OFS_ALT_SET, 32'hffff_ffff, 4'hf, '0, '0, '0);
    // Clock enable low freezes the state
    @(posedge clk);
    ce <= 1'b0;
    cyc_done <= '1;
    hw_clr <= '1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    cyc_done <= 14'h0005;
    hw_set <= 14'h0300;
    hw_clr <= 14'h0101;
    @(posedge clk);
    cyc_done <= '0;
    hw_set <= '0;
    hw_clr <= '0;
    exp_en = exp_en & ~14'h0005;
    exp_alt = exp_alt & ~14'h0101;
    axi_rd(dcea_pkg::OFS_EN_CLR);
    axi_rd(dcea_pkg::OFS_ALT_CLR);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    exp_en = '0;
    exp_alt = '0;
    axi_rd(dcea_pkg::OFS_EN_SET);
    axi_rd(dcea_pkg::OFS_ALT_SET);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
